// File: hdl/pid_pkg.sv
// Package for the prefix instruction decoder: codes, timing and carriers.
// Assumes a single 10 MHz core clock and byte-wide instruction fetch.
package pid_pkg;

  // Clock and timing
  localparam int unsigned CORE_CLK_HZ            = 10_000_000;
  localparam int unsigned INPUT_CLOCK_HZ         = 5_000_000;
  localparam int unsigned PLL_MULTIPLIER_X10     = 40;
  localparam int unsigned PROCESSOR_CYCLE_NS     = 50;
  localparam int unsigned CORE_PERIOD_NS         = 1_000_000_000 / CORE_CLK_HZ;
  localparam int unsigned PROC_CYCLE_CLKS_RAW    = PROCESSOR_CYCLE_NS / CORE_PERIOD_NS;
  localparam int unsigned PROCESSOR_CYCLE_CLKS   =
    (PROC_CYCLE_CLKS_RAW < 1) ? 1 : PROC_CYCLE_CLKS_RAW;

  // Byte layout
  localparam int unsigned FN_MSB   = 7;
  localparam int unsigned FN_LSB   = 4;
  localparam int unsigned NIB_MSB  = 3;
  localparam int unsigned NIB_LSB  = 0;
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned WORD_W   = 32;

  // Function codes
  localparam logic [3:0] FN_JUMP   = 4'h0;
  localparam logic [3:0] FN_PREFIX = 4'h2;
  localparam logic [3:0] FN_LDC    = 4'h4;
  localparam logic [3:0] FN_NEGPFX = 4'h6;
  localparam logic [3:0] FN_ADC    = 4'h8;
  localparam logic [3:0] FN_OPR    = 4'hf;

  // Operation codes
  localparam logic [31:0] OP_ADD      = 32'h0000_0005;
  localparam logic [31:0] OP_LDDEVID  = 32'h0000_017c;
  localparam logic [31:0] OP_FPENTRY  = 32'h0000_00ab;
  localparam logic [31:0] OP_FPADD    = 32'h0000_0087;
  localparam logic [31:0] OP_FPCHKERR = 32'h0000_0083;

  // Cycle figures for the basic operation
  localparam logic [7:0] CYC_ONE     = 8'h01;
  localparam logic [7:0] CYC_JUMP    = 8'h03;
  localparam logic [7:0] CYC_PREFIX  = 8'h01;
  localparam logic [7:0] CYC_OPR_DEF = 8'h01;
  localparam logic [7:0] CYC_VAR_BASE = 8'h04;

  // Reset values
  localparam logic [31:0] OPERAND_RST = 32'h0000_0000;
  localparam logic [7:0]  COUNT_RST   = 8'h00;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pid_byte_t;

  typedef struct packed {
    logic descheduling;
    logic main_error;
    logic float_error_flag;
  } pid_feat_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  func;
    logic [31:0] operand;
    logic        is_opr;
    pid_feat_t   feat;
    logic [7:0]  cycles;
  } pid_issue_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] selector;
  } pid_fpu_t;

endpackage

// File: hdl/pid_clk_div.sv
// Divider giving a one-cycle enable per processor cycle.
// Assumes the core clock is at least the processor cycle rate.
`timescale 1ns/1ps
module pid_clk_div
  import pid_pkg::*;
#(
  parameter int unsigned DIV = PROCESSOR_CYCLE_CLKS
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Enable
  output logic      tick
);

  initial begin
    if (DIV < 1 || DIV > 255) begin
      $error("pid_clk_div: DIV out of range");
    end
  end

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } pid_div_st_t;

  pid_div_st_t st_q;
  pid_div_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (st_q.cnt == 8'(DIV - 1)) begin
      st_d.cnt  = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt  = st_q.cnt + 8'h01;
      st_d.tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule

// File: hdl/pid_decoder.sv
// Prefix instruction decoder: builds operands from byte chains and issues instructions.
// Assumes bytes come from same-clock fetch logic; A register value is supplied by the core.
`timescale 1ns/1ps
module pid_decoder
  import pid_pkg::*;
#(
  parameter logic [31:0] DEVICE_ID = 32'h0000_0064  // Arbitrary identity value
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Instruction byte fetch
  input  pid_byte_t        fetch,
  output logic             fetch_ready,
  // Core state
  input  wire logic [31:0] areg,
  input  wire logic [31:0] msg_addr,
  input  wire logic [31:0] msg_len,
  input  wire logic        fpu_busy,
  // Issued instruction, message word count and processor cycle enable
  output pid_issue_t       issue,
  output logic             push_a,
  output logic [31:0]      push_a_value,
  output pid_fpu_t         fpu_cmd,
  output logic [31:0]      msg_words,
  output logic             proc_tick
);

  // Figures the decoder logic is built around
  initial begin
    if (PLL_MULTIPLIER_X10 * INPUT_CLOCK_HZ / 10 != 1000 / PROCESSOR_CYCLE_NS * 1_000_000) begin
      $error("pid_decoder: processor clock figures disagree");
    end
    if (WORD_W != 32 || NIB_W != 4) begin
      $error("pid_decoder: operand logic needs 4-bit nibbles in 32-bit words");
    end
    if (FN_MSB - FN_LSB + 1 != NIB_W || NIB_MSB - NIB_LSB + 1 != NIB_W) begin
      $error("pid_decoder: byte fields do not match the nibble width");
    end
    if (PROCESSOR_CYCLE_CLKS > 255) begin
      $error("pid_decoder: processor cycle too long for the divider");
    end
  end

  typedef struct packed {
    logic [31:0] oreg;
    logic [7:0]  pfx_cnt;
    pid_issue_t  issue;
    logic        push_a;
    logic [31:0] push_val;
    pid_fpu_t    fpu;
    logic [31:0] msg_words;
    logic        ready;
    logic        tick;
  } pid_dec_st_t;

  pid_dec_st_t st_q;
  pid_dec_st_t st_d;
  logic        tick_w;

  // Processor cycle enable
  pid_clk_div #(
    .DIV (PROCESSOR_CYCLE_CLKS)
  ) u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick_w)
  );

  // Highest set bit index of a word, zero when none
  function automatic logic [7:0] top_bit(input logic [31:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < WORD_W; i++) begin
      if (v[i]) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction

  // Words spanned by a byte message, partial words counted whole
  function automatic logic [31:0] span_words(input logic [31:0] addr, input logic [31:0] len);
    logic [33:0] first;
    logic [33:0] last;
    first = {2'b00, addr} >> 2;
    last  = ({2'b00, addr} + {2'b00, len} + 34'h3) >> 2;
    return (len == 32'h0) ? 32'h0 : 32'(last - first);
  endfunction

  // Prefix cycle tally, held at its ceiling so a runaway chain cannot wrap
  function automatic logic [7:0] pfx_next(input logic [7:0] cnt);
    logic [7:0] n;
    n = cnt + CYC_PREFIX;
    if (n < cnt) begin
      n = 8'hff;
    end
    return n;
  endfunction

  // Descheduling and error attributes of a finished instruction
  function automatic pid_feat_t feat_of(input logic [3:0] fn, input logic [31:0] opnd,
                                        input logic [31:0] a_val);
    pid_feat_t f;
    f = '0;
    if (fn == FN_JUMP) begin
      f.descheduling = 1'b1;
    end
    if (fn == FN_ADC) begin
      f.main_error = 1'b1;
    end
    if (fn == FN_OPR && (opnd == OP_ADD || opnd == OP_FPCHKERR)) begin
      f.main_error = 1'b1;
    end
    if (fn == FN_OPR && opnd == OP_FPENTRY) begin
      f.float_error_flag = (a_val == OP_FPADD);
    end
    return f;
  endfunction

  // Basic cycles of a finished instruction, prefix bytes not yet added
  function automatic logic [7:0] cycles_of(input logic [3:0] fn, input logic [31:0] opnd,
                                           input logic [31:0] a_val);
    logic [7:0] c;
    c = CYC_ONE;
    if (fn == FN_JUMP) begin
      c = CYC_JUMP;
    end
    if (fn == FN_OPR) begin
      c = CYC_OPR_DEF;
      if (opnd == OP_ADD && a_val[31]) begin
        c = CYC_VAR_BASE + top_bit(a_val);
      end
    end
    return c;
  endfunction

  always_comb begin
    logic [3:0]  fn;
    logic [3:0]  nib;
    logic [31:0] opnd;
    logic [7:0]  cyc;
    fn   = fetch.data[FN_MSB:FN_LSB];
    nib  = fetch.data[NIB_MSB:NIB_LSB];
    opnd = st_q.oreg | {28'h0, nib};
    cyc  = cycles_of(fn, opnd, areg);
    st_d = st_q;
    st_d.tick        = tick_w;
    st_d.issue.valid = 1'b0;
    st_d.push_a      = 1'b0;
    st_d.fpu.valid   = 1'b0;
    st_d.ready       = 1'b1;
    st_d.msg_words   = span_words(msg_addr, msg_len);
    if (fetch.valid && st_q.ready) begin
      // Prefix bytes give no answer; the chain waits for its function byte
      case (fn)
        FN_PREFIX: begin
          st_d.oreg    = opnd << NIB_W;
          st_d.pfx_cnt = pfx_next(st_q.pfx_cnt);
        end
        FN_NEGPFX: begin
          st_d.oreg    = (~opnd) << NIB_W;
          st_d.pfx_cnt = pfx_next(st_q.pfx_cnt);
        end
        default: begin
          // The final byte consumes the operand and issues the instruction
          st_d.oreg          = OPERAND_RST;
          st_d.pfx_cnt       = COUNT_RST;
          st_d.issue.valid   = 1'b1;
          st_d.issue.func    = fn;
          st_d.issue.operand = opnd;
          st_d.issue.is_opr  = (fn == FN_OPR);
          st_d.issue.feat    = feat_of(fn, opnd, areg);
          if (fn == FN_LDC) begin
            st_d.push_a       = 1'b1;
            st_d.push_val     = opnd;
          end
          if (fn == FN_OPR) begin
            if (opnd == OP_LDDEVID) begin
              st_d.push_a   = 1'b1;
              st_d.push_val = DEVICE_ID;
            end
            if (opnd == OP_FPENTRY) begin
              st_d.fpu.valid    = 1'b1;
              st_d.fpu.selector = areg;
            end
          end
          // Concurrency: FPU busy never stalls integer issue
          st_d.issue.cycles = cyc + st_q.pfx_cnt;
        end
      endcase
    end
    // FPU busy is only watched; a new selector is still passed on
    if (fpu_busy && st_d.fpu.valid) begin
      st_d.fpu.valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fetch_ready  = st_q.ready;
  assign issue        = st_q.issue;
  assign push_a       = st_q.push_a;
  assign push_a_value = st_q.push_val;
  assign fpu_cmd      = st_q.fpu;
  assign msg_words    = st_q.msg_words;
  assign proc_tick    = st_q.tick;

endmodule

// File: dv/pid_fetch_model.sv
// Instruction byte source in place of processor memory.
// Tasks are called just after a rising edge of core_clk.
`timescale 1ns/1ps
module pid_fetch_model
  import pid_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic fetch_ready,
  output pid_byte_t fetch
);
  initial fetch = '0;
  task put(input logic [7:0] b);
    fetch <= '{valid: 1'h1, data: b};
    @(posedge core_clk);
    while (fetch_ready !== 1'h1) @(posedge core_clk);
  endtask
  // Released bus shows the inverse of the last byte
  task idle;
    fetch <= '{valid: 1'h0, data: ~fetch.data};
  endtask
endmodule

// File: dv/pid_decoder_monitor.sv
// Port assertions for the prefix instruction decoder.
// Bound to every pid_decoder instance.
`timescale 1ns/1ps
module pid_decoder_monitor
  import pid_pkg::*;
#(
  parameter logic [31:0] DEVICE_ID = 32'h0000_0064
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Fetch and core state
  input pid_byte_t        fetch,
  input wire logic        fetch_ready,
  input wire logic [31:0] areg,
  input wire logic        fpu_busy,
  // Results
  input pid_issue_t       issue,
  input wire logic        push_a,
  input wire logic [31:0] push_a_value,
  input pid_fpu_t         fpu_cmd
);
  wire       take = fetch.valid && fetch_ready;
  wire [3:0] fn   = fetch.data[7:4];
  wire [3:0] nib  = fetch.data[3:0];
  wire       pfx  = take && (fn == FN_PREFIX || fn == FN_NEGPFX);
  wire       fin  = take && !pfx;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_pfx;
    !pfx ##1 take && fn == FN_PREFIX;
  endsequence
  sequence s_nfx;
    !pfx ##1 take && fn == FN_NEGPFX;
  endsequence
  fin_issue_a: assert property (fin |=> issue.valid) else $error("no issue");
  pfx_quiet_a: assert property (pfx |=> !issue.valid) else $error("prefix issued");
  one_byte_a: assert property (!pfx ##1 fin |=> issue.operand == {28'h0, $past(nib)})
    else $error("short operand");
  pfx_chain_a: assert property (s_pfx ##1 fin |=>
    issue.operand == {24'h0, $past(nib, 2), $past(nib)}) else $error("prefix operand");
  nfx_chain_a: assert property (s_nfx ##1 fin |=>
    issue.operand == {24'hffffff, ~$past(nib, 2), $past(nib)}) else $error("neg operand");
  pfx_cycle_a: assert property (s_pfx ##1 fin && fn == FN_OPR && !areg[31] |=>
    issue.cycles == 8'h02) else $error("prefix cycles");
  opr_flag_a: assert property (fin && fn == FN_OPR |=> issue.is_opr) else $error("opr");
  dev_push_a: assert property (issue.valid && issue.is_opr && issue.operand == OP_LDDEVID
    |-> push_a && push_a_value == DEVICE_ID) else $error("identity");
  fp_select_a: assert property (issue.valid && issue.is_opr && issue.operand == OP_FPENTRY
    |-> fpu_cmd.valid && fpu_cmd.selector == $past(areg)) else $error("selector");
  no_stall_a: assert property (fpu_busy && $past(rst_n) |-> fetch_ready) else $error("stall");
  jump_sched_a: assert property (issue.valid && issue.func == FN_JUMP
    |-> issue.feat.descheduling) else $error("desched");
endmodule
bind pid_decoder pid_decoder_monitor #(.DEVICE_ID(DEVICE_ID)) mon (.core_clk, .rst_n, .fetch,
  .fetch_ready, .areg, .fpu_busy, .issue, .push_a, .push_a_value, .fpu_cmd);

// File: dv/test_pid_decoder.sv
// Self-checking bench for the prefix instruction decoder.
// Uses the fetch model; the port monitor is bound in.
`timescale 1ns/1ps
module test_pid_decoder;
  import pid_pkg::*;
  localparam logic [31:0] DEV = 32'h0000_0064;  // Arbitrary identity value
  logic        core_clk = 1'h0;
  logic        rst_n    = 1'h0;
  logic        fpu_busy = 1'h0;
  logic [31:0] areg     = '0;
  logic [31:0] msg_addr = '0;
  logic [31:0] msg_len  = '0;
  logic        fetch_ready, push_a, proc_tick;
  logic [31:0] push_a_value, msg_words;
  pid_byte_t   fetch;
  pid_issue_t  issue;
  pid_fpu_t    fpu_cmd;
  logic [7:0]  bq[$];
  int          err_total = 0;
  int          n_checks  = 0;
  always #50 core_clk = ~core_clk;
  pid_fetch_model m (.core_clk, .fetch_ready, .fetch);
  pid_decoder #(.DEVICE_ID(DEV)) uut (.core_clk, .rst_n, .fetch, .fetch_ready, .areg,
    .msg_addr, .msg_len, .fpu_busy, .issue, .push_a, .push_a_value, .fpu_cmd, .msg_words,
    .proc_tick);
  task stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string s);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %0t %s: %h not %h", $time, s, g, e);
    end
  endtask
  // Sends the queued bytes back to back, then samples the answer
  task run;
    @(posedge core_clk);
    foreach (bq[i]) m.put(bq[i]);
    m.idle;
    #1;
    chk(issue.valid, 1'h1, "valid");
    chk(issue.func, bq[bq.size()-1][7:4], "func");
  endtask
  task t_ldc;
    bq = '{8'h43};
    run;
    chk(issue.operand, 32'h3, "ldc");
    chk(issue.cycles, 8'h01, "cyc1");
    chk(push_a, 1'h1, "ldc push");
    chk(push_a_value, 32'h3, "ldc value");
  endtask
  task t_pfx;
    bq = '{8'h29, 8'h28, 8'h47};
    run;
    chk(issue.operand, 32'h987, "pfx");
    chk(issue.cycles, 8'h03, "cyc3");
  endtask
  task t_neg;
    bq = '{8'h61, 8'h41};
    run;
    chk(issue.operand, 32'hffff_ffe1, "nfix");
  endtask
  task t_opr;
    bq = '{8'h21, 8'hf6};
    run;
    chk(issue.operand, 32'h16, "opcode");
    chk(issue.is_opr, 1'h1, "opr");
  endtask
  task t_var;
    @(posedge core_clk);
    areg <= 32'h8000_0000;
    bq = '{8'hf5};
    run;
    chk(issue.cycles, 8'h23, "var");
    chk(issue.feat.main_error, 1'h1, "err");
  endtask
  task t_dev;
    bq = '{8'h21, 8'h27, 8'hfc};
    run;
    chk(push_a, 1'h1, "push");
    chk(push_a_value, DEV, "devid");
  endtask
  task t_fpe;
    @(posedge core_clk);
    areg <= 32'h87;
    fpu_busy <= 1'h1;
    bq = '{8'h2a, 8'hfb};
    run;
    chk(fpu_cmd.selector, OP_FPADD, "sel");
    chk(fetch_ready, 1'h1, "busy");
    chk(fpu_cmd.valid, 1'h1, "fpu valid");
    chk(issue.feat.float_error_flag, 1'h1, "fp flag");
  endtask
  task t_jmp;
    bq = '{8'h05};
    run;
    chk(issue.feat.descheduling, 1'h1, "desched");
    chk(issue.cycles, 8'h03, "jcyc");
    chk(proc_tick, 1'h1, "tick");
  endtask
  task t_msg;
    @(posedge core_clk);
    msg_addr <= 32'h3;
    msg_len <= 32'h6;
    repeat (2) @(posedge core_clk);
    #1;
    chk(msg_words, 32'h3, "words");
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
    t_ldc;
    t_pfx;
    t_neg;
    t_opr;
    t_var;
    t_dev;
    t_fpe;
    t_jmp;
    t_msg;
    stop_test;
  end
  initial begin
    #100000;
    err_total++;
    stop_test;
  end
endmodule
